//--- common/ceram_pkg.sv
package ceram_pkg;

	// Capacity classes
	localparam int CLS_SMALL = 0;
	localparam int CLS_MEDIUM = 1;
	localparam int CLS_LARGE = 2;

	// Full word = data bits plus one parity bit per byte
	function automatic int word_bits(int cls);
		return (cls == CLS_SMALL) ? 18 : (cls == CLS_MEDIUM) ? 36 : 144;
	endfunction : word_bits

	function automatic int data_bits(int cls);
		return (cls == CLS_SMALL) ? 16 : (cls == CLS_MEDIUM) ? 32 : 128;
	endfunction : data_bits

	function automatic int data_log2(int cls);
		return (cls == CLS_SMALL) ? 4 : (cls == CLS_MEDIUM) ? 5 : 7;
	endfunction : data_log2

	// Word address bits: 32, 128 and 4K words
	function automatic int addr_bits(int cls);
		return (cls == CLS_SMALL) ? 5 : (cls == CLS_MEDIUM) ? 7 : 12;
	endfunction : addr_bits

	function automatic int port_addr_bits(int cls);
		return addr_bits(cls) + data_log2(cls);
	endfunction : port_addr_bits

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_WIDTH = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_WCOUNT = 8'h0c;

	// Control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_OLD_DATA = 3;
	localparam int CTRL_OUTREG_A = 4;
	localparam int CTRL_OUTREG_B = 5;
	localparam int CTRL_FLOW = 6;
	localparam int CTRL_BITS = 7;
	localparam logic [6:0] CTRL_RESET = 7'h38;

	// Width fields: log2 of port width, or the full-word code
	localparam int WID_A_LSB = 0;
	localparam int WID_B_LSB = 4;
	localparam logic [3:0] WID_FULL = 4'hf;
	localparam logic [7:0] WIDTH_RESET = 8'hff;

	// Status fields
	localparam int STAT_COLL = 0;
	localparam int STAT_CLASS_LSB = 4;

	localparam int WCOUNT_BITS = 16;
	localparam logic [15:0] WCOUNT_RESET = 16'h0000;

	// AHB-Lite encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [2:0] {
		MODE_SDP,
		MODE_TDP,
		MODE_SP,
		MODE_DSP,
		MODE_ROM
	} ceram_mode_t;

endpackage : ceram_pkg

//--- hw/ceram_array.sv
`timescale 1ns/10ps
module ceram_array #(
	parameter int W = 36,
	parameter int AW = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Two access ports
	input wire logic [1:0] en,
	input wire logic [1:0] we,
	input wire logic [1:0][AW-1:0] addr,
	input wire logic [1:0][W-1:0] wdata,
	input wire logic [1:0][W-1:0] wmask,
	input wire logic [1:0][7:0] rsh,
	input wire logic [1:0][W-1:0] rmask,
	input wire logic [1:0] clr,
	input wire logic old_data,
	// Read data, registered
	output logic [1:0][W-1:0] q
);

	logic [W-1:0] mem [0:(1<<AW)-1];
	logic [1:0][W-1:0] merged;

	// Byte and lane masking merges into the stored word
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			merged[p] = (mem[addr[p]] & ~wmask[p]) | (wdata[p] & wmask[p]);
		end
	end

	// Port B is written last, so it wins a same-word double write
	always_ff @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			if (we[p]) begin
				mem[addr[p]] <= merged[p];
			end
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_rd
		localparam int O = 1 - p;
		logic [W-1:0] q_r;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				q_r <= '0;
			end else if (clr[p]) begin
				q_r <= '0;
			end else if (en[p]) begin
				if (we[p]) begin
					q_r <= (merged[p] >> rsh[p]) & rmask[p];
				end else if (we[O] && addr[O] == addr[p] && !old_data) begin
					q_r <= '0;
				end else begin
					q_r <= (mem[addr[p]] >> rsh[p]) & rmask[p];
				end
			end
		end
		assign q[p] = q_r;
	end

endmodule : ceram_array

//--- hw/ceram_top.sv
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - Three classes: 32x18, 128x36 and 4Kx144 full-width organisations.
// - Medium and large offer true dual-port, any read/write mix per port.
// - Simple dual-port reads and writes together; same-word read gives old data or zeros.
// - Single-port unregistered output shows written data once the write completes.
// - Single-port registered output shows written data after the next enabled rising edge.
// - Address, data and enables are all captured on the port clock.
// - Write strobe is timed internally from the port clock.
// - Each read port has a bypassable output register.
// - Small and medium simple dual-port support flow-through reads.
// - Dual-port ports may use different widths over the same storage.
// - Medium block hosts two single-port memories, each at most half size.
// - Input clear acts at once; memory output shows it from the next edge.
// - Output clear resets output registers, visible immediately.
// - Small and medium clear inputs and outputs; large clears outputs only.
// - Blocks side by side on a shared address form wider memories.
// - Every class works with or without parity in all listed arrangements.
// - One parity bit stored per data byte; checking is left outside.
// - Medium and large honour per-byte write enables at full port width only.
module ceram_top #(
	parameter int ram_class = ceram_pkg::CLS_MEDIUM
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite register slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Port A
	input wire logic clken_a,
	input wire logic [ceram_pkg::port_addr_bits(ram_class)-1:0] addr_a,
	input wire logic [ceram_pkg::word_bits(ram_class)-1:0] wdata_a,
	input wire logic wren_a,
	input wire logic rden_a,
	input wire logic [ceram_pkg::data_bits(ram_class)/8-1:0] byteen_a,
	input wire logic inclr_a,
	input wire logic outclr_a,
	output logic [ceram_pkg::word_bits(ram_class)-1:0] q_a,
	// Port B
	input wire logic clken_b,
	input wire logic [ceram_pkg::port_addr_bits(ram_class)-1:0] addr_b,
	input wire logic [ceram_pkg::word_bits(ram_class)-1:0] wdata_b,
	input wire logic wren_b,
	input wire logic rden_b,
	input wire logic [ceram_pkg::data_bits(ram_class)/8-1:0] byteen_b,
	input wire logic inclr_b,
	input wire logic outclr_b,
	output logic [ceram_pkg::word_bits(ram_class)-1:0] q_b
);

	localparam int W = ceram_pkg::word_bits(ram_class);
	localparam int D = ceram_pkg::data_bits(ram_class);
	localparam int NB = D / 8;
	localparam int LD = ceram_pkg::data_log2(ram_class);
	localparam int AW = ceram_pkg::addr_bits(ram_class);
	localparam int PAW = ceram_pkg::port_addr_bits(ram_class);
	localparam logic TDP_OK = (ram_class != ceram_pkg::CLS_SMALL);
	localparam logic DSP_OK = (ram_class == ceram_pkg::CLS_MEDIUM);
	localparam logic BE_OK = (ram_class != ceram_pkg::CLS_SMALL);
	localparam logic INCLR_OK = (ram_class != ceram_pkg::CLS_LARGE);
	localparam logic FLOW_OK = (ram_class != ceram_pkg::CLS_LARGE);

	typedef struct packed {
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [6:0] ctrl;
		logic [7:0] width;
		logic coll;
		logic [15:0] wcount;
		logic [31:0] hrdata;
		logic rdy;
		logic resp;
		logic [1:0][W-1:0] out;
	} ceram_state_t;

	ceram_state_t s_r, s_nxt;

	// Both ports handled as arrays
	logic [1:0] p_clken, p_wren, p_rden, p_inclr, p_outclr;
	logic [1:0][PAW-1:0] p_addr;
	logic [1:0][W-1:0] p_wdata;
	logic [1:0][NB-1:0] p_be;
	logic [1:0][W-1:0] be_mask;

	assign p_clken = {clken_b, clken_a};
	assign p_wren = {wren_b, wren_a};
	assign p_rden = {rden_b, rden_a};
	assign p_inclr = {inclr_b, inclr_a};
	assign p_outclr = {outclr_b, outclr_a};
	assign p_addr = {addr_b, addr_a};
	assign p_wdata = {wdata_b, wdata_a};
	assign p_be = {byteen_b, byteen_a};

	// Parity bit of each byte rides with that byte's enable
	for (genvar p = 0; p < 2; p++) begin : g_port
		for (genvar b = 0; b < NB; b++) begin : g_byte
			assign be_mask[p][8*b +: 8] = {8{p_be[p][b] | ~BE_OK}};
			assign be_mask[p][D+b] = p_be[p][b] | ~BE_OK;
		end
	end

	ceram_pkg::ceram_mode_t mode;
	logic [1:0] wok, rok;
	logic dsp_on, flow_on;

	assign mode = ceram_pkg::ceram_mode_t'(s_r.ctrl[ceram_pkg::CTRL_MODE_LSB +: 3]);
	assign flow_on = FLOW_OK && s_r.ctrl[ceram_pkg::CTRL_FLOW] && mode == ceram_pkg::MODE_SDP;

	// Which port may write and read in each arrangement
	always_comb begin
		wok = 2'b01;
		rok = 2'b10;
		dsp_on = 1'b0;
		unique case (mode)
			ceram_pkg::MODE_SDP: begin
				wok = 2'b01;
				rok = 2'b10;
			end
			ceram_pkg::MODE_TDP: begin
				if (TDP_OK) begin
					wok = 2'b11;
					rok = 2'b11;
				end
			end
			ceram_pkg::MODE_SP: begin
				wok = 2'b01;
				rok = 2'b01;
			end
			ceram_pkg::MODE_DSP: begin
				wok = {DSP_OK, 1'b1};
				rok = {DSP_OK, 1'b1};
				dsp_on = DSP_OK;
			end
			ceram_pkg::MODE_ROM: begin
				wok = 2'b00;
				rok = 2'b11;
			end
			default: begin
				wok = 2'b01;
				rok = 2'b10;
			end
		endcase
	end

	// Per-port width, lane and address decode
	logic [1:0] full, in_act, m_en, m_we, m_clr;
	logic [1:0][3:0] wl;
	logic [1:0][7:0] lg, shw, off;
	logic [1:0][W-1:0] lm, m_wdata, m_wmask, m_rmask;
	logic [1:0][7:0] m_rsh;
	logic [1:0][AW-1:0] m_addr;
	logic [1:0][PAW-1:0] lane;
	logic [1:0][PAW-1:0] wsel;
	logic [1:0][W-1:0] mem_q;

	always_comb begin
		for (int p = 0; p < 2; p++) begin
			wl[p] = (p == 0) ? s_r.width[ceram_pkg::WID_A_LSB +: 4] : s_r.width[ceram_pkg::WID_B_LSB +: 4];
			full[p] = wl[p] > 4'(LD);
			lg[p] = full[p] ? 8'(LD) : 8'(wl[p]);
			shw[p] = 8'(LD) - lg[p];
			wsel[p] = p_addr[p] >> shw[p];
			lane[p] = p_addr[p] & ((PAW'(1) << shw[p]) - PAW'(1));
			off[p] = 8'(lane[p] << lg[p]);
			lm[p] = {W{1'b1}} >> (W - (1 << lg[p]));
			m_addr[p] = wsel[p][AW-1:0];
			if (dsp_on) begin
				m_addr[p][AW-1] = (p == 1);
			end
			m_wdata[p] = full[p] ? p_wdata[p] : (p_wdata[p] & lm[p]) << off[p];
			m_wmask[p] = full[p] ? be_mask[p] : lm[p] << off[p];
			m_rsh[p] = full[p] ? 8'h00 : off[p];
			m_rmask[p] = full[p] ? {W{1'b1}} : lm[p];
			in_act[p] = INCLR_OK && p_inclr[p];
			// Inputs go straight into the array's capture edge; a write
			// needs no user-shaped strobe, only the enable at the edge
			m_we[p] = p_clken[p] && p_wren[p] && wok[p] && !in_act[p];
			// A single-port request with both enables writes and reads back the new word
			m_en[p] = m_we[p] || (p_clken[p] && p_rden[p] && rok[p] && !in_act[p]);
			m_clr[p] = in_act[p];
		end
	end

	ceram_array #(
		.W(W),
		.AW(AW)
	) u_array (
		.clk(hclk),
		.rst_n(hresetn),
		.en(m_en),
		.we(m_we),
		.addr(m_addr),
		.wdata(m_wdata),
		.wmask(m_wmask),
		.rsh(m_rsh),
		.rmask(m_rmask),
		.clr(m_clr),
		.old_data(s_r.ctrl[ceram_pkg::CTRL_OLD_DATA]),
		.q(mem_q)
	);

	logic coll_ev;
	assign coll_ev = (m_we[0] && m_en[1] && !m_we[1] && m_addr[0] == m_addr[1])
		|| (m_we[1] && m_en[0] && !m_we[0] && m_addr[0] == m_addr[1]);

	function automatic logic [31:0] reg_read(ceram_state_t st, logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			ceram_pkg::REG_CTRL: v[ceram_pkg::CTRL_BITS-1:0] = st.ctrl;
			ceram_pkg::REG_WIDTH: v[7:0] = st.width;
			ceram_pkg::REG_STATUS: begin
				v[ceram_pkg::STAT_COLL] = st.coll;
				v[ceram_pkg::STAT_CLASS_LSB +: 2] = 2'(ram_class);
			end
			ceram_pkg::REG_WCOUNT: v[ceram_pkg::WCOUNT_BITS-1:0] = st.wcount;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : reg_read

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdy = 1'b1;
		s_nxt.resp = 1'b0;
		// Data phase of a write
		if (s_r.ap_valid && s_r.ap_write) begin
			case (s_r.ap_addr)
				ceram_pkg::REG_CTRL: s_nxt.ctrl = hwdata[ceram_pkg::CTRL_BITS-1:0];
				ceram_pkg::REG_WIDTH: s_nxt.width = hwdata[7:0];
				ceram_pkg::REG_STATUS: begin
					if (hwdata[ceram_pkg::STAT_COLL]) begin
						s_nxt.coll = 1'b0;
					end
				end
				ceram_pkg::REG_WCOUNT: s_nxt.wcount = ceram_pkg::WCOUNT_RESET;
				default: s_nxt.ctrl = s_r.ctrl;
			endcase
		end
		// Hardware events win over a software clear in the same cycle
		if (coll_ev) begin
			s_nxt.coll = 1'b1;
		end
		if (m_we != 2'b00) begin
			s_nxt.wcount = s_nxt.wcount + 16'h0001;
		end
		// Address phase; read data taken after any write just landed
		s_nxt.ap_valid = hsel && htrans[1] && hready && hsize == ceram_pkg::HSIZE_WORD;
		s_nxt.ap_write = hwrite;
		s_nxt.ap_addr = {haddr[7:2], 2'b00};
		if (s_nxt.ap_valid && !hwrite) begin
			s_nxt.hrdata = reg_read(s_nxt, s_nxt.ap_addr);
		end
		// Output registers follow the array one port-clock edge later
		for (int p = 0; p < 2; p++) begin
			if (p_outclr[p]) begin
				s_nxt.out[p] = '0;
			end else if (p_clken[p]) begin
				s_nxt.out[p] = mem_q[p];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '{ap_valid: 1'b0, ap_write: 1'b0, ap_addr: 8'h00, ctrl: ceram_pkg::CTRL_RESET,
				width: ceram_pkg::WIDTH_RESET, coll: 1'b0, wcount: ceram_pkg::WCOUNT_RESET,
				hrdata: 32'h0000_0000, rdy: 1'b1, resp: 1'b0, out: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hrdata = s_r.hrdata;
	assign hreadyout = s_r.rdy;
	assign hresp = s_r.resp;

	// Output clear bypasses the flops so it shows without waiting for an edge
	logic reg_a, reg_b;
	assign reg_a = s_r.ctrl[ceram_pkg::CTRL_OUTREG_A];
	assign reg_b = s_r.ctrl[ceram_pkg::CTRL_OUTREG_B] && !flow_on;
	assign q_a = outclr_a ? '0 : (reg_a ? s_r.out[0] : mem_q[0]);
	assign q_b = outclr_b ? '0 : (reg_b ? s_r.out[1] : mem_q[1]);

endmodule : ceram_top

//--- verification/ceram_checker.sv
`timescale 1ns/10ps
module ceram_checker #(
	parameter int ram_class = ceram_pkg::CLS_MEDIUM
) (
	// Clock, reset and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Port controls and data
	input wire logic clken_a,
	input wire logic inclr_a,
	input wire logic outclr_a,
	input wire logic [ceram_pkg::word_bits(ram_class)-1:0] q_a,
	input wire logic clken_b,
	input wire logic inclr_b,
	input wire logic outclr_b,
	input wire logic [ceram_pkg::word_bits(ram_class)-1:0] q_b
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	zero_wait_a: assert property (hreadyout) else $error("hreadyout low");
	okay_resp_a: assert property (!hresp) else $error("hresp not okay");
	rdata_hold_a: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata)) else $error("hrdata moved");
	clear_qa_a: assert property (outclr_a |-> q_a == '0) else $error("q_a not cleared");
	clear_qb_a: assert property (outclr_b |-> q_b == '0) else $error("q_b not cleared");
	// Bus writes are excluded because they may switch the output register bypass
	hold_qa_a: assert property (!clken_a && !inclr_a && !outclr_a && !hsel ##1 !outclr_a |-> $stable(q_a))
		else $error("q_a moved while idle");
	hold_qb_a: assert property (!clken_b && !inclr_b && !outclr_b && !hsel ##1 !outclr_b |-> $stable(q_b))
		else $error("q_b moved while idle");
	reset_out_a: assert property ($rose(hresetn) |-> q_a == '0 && q_b == '0 && hrdata == '0)
		else $error("outputs not cleared by reset");
endmodule : ceram_checker

//--- verification/ceram_top_tb.sv
`timescale 1ns/10ps
module ceram_top_tb;
	localparam int CLS = ceram_pkg::CLS_MEDIUM;
	localparam int W = ceram_pkg::word_bits(CLS);
	localparam int AB = ceram_pkg::port_addr_bits(CLS);
	localparam int BE = ceram_pkg::data_bits(CLS) / 8;
	typedef struct {logic [7:0] a; logic [31:0] v;} ceram_row_t;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic clken_a, wren_a, rden_a, inclr_a, outclr_a, clken_b, wren_b, rden_b, inclr_b, outclr_b;
	logic [AB-1:0] addr_a, addr_b;
	logic [W-1:0] wdata_a, wdata_b, q_a, q_b;
	logic [BE-1:0] byteen_a, byteen_b;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	// Register offset beside its value after reset; 0x10 is unmapped
	ceram_row_t rows [5] = '{'{8'h00, 32'h38}, '{8'h04, 32'hff}, '{8'h08, 32'h10}, '{8'h0c, 32'h0}, '{8'h10, 32'h0}};

	ceram_top #(.ram_class(CLS)) i_dut (.hsize(ceram_pkg::HSIZE_WORD), .hready(hreadyout), .*);
	ceram_user #(.ram_class(CLS)) i_usr (.*);

	task automatic chk(input string n, input logic [W-1:0] e, input logic [W-1:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// One AHB-Lite single word transfer, then one idle edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
		hsel <= 1'b0;
		hwdata <= ~d;
		@(posedge hclk);
	endtask : ahb

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		inclr_a = 1'b0;
		outclr_a = 1'b0;
		inclr_b = 1'b0;
		outclr_b = 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i]) begin
			ahb(1'b0, rows[i].a, 32'h0);
			chk("register", W'(rows[i].v), W'(r));
		end
		$display("test registers done");
		ahb(1'b1, 8'h00, 32'h02);
		i_usr.op(1'b1, 1'b0, 'h5, 36'h5_1234_5678, 4'hf, 1'b0, '0);
		#1 chk("q_a", 36'h5_1234_5678, q_a);
		@(posedge hclk);
		i_usr.op(1'b1, 1'b0, 'h5, 36'h5_aabb_ccdd, 4'h1, 1'b0, '0);
		#1 chk("q_a", 36'h5_1234_56dd, q_a);
		@(posedge hclk);
		$display("test single port done");
		ahb(1'b1, 8'h00, 32'h12);
		outclr_a <= 1'b1;
		outclr_b <= 1'b1;
		#1 chk("q_a", '0, q_a);
		chk("q_b", '0, q_b);
		@(posedge hclk);
		outclr_a <= 1'b0;
		outclr_b <= 1'b0;
		i_usr.op(1'b1, 1'b0, 'h6, 36'h3_0f0f_0f0f, 4'hf, 1'b0, '0);
		// Cleared by outclr, the output register took the array's previous read word at this write edge; the new word follows at the next enabled edge
		#1 chk("q_a", 36'h5_1234_56dd, q_a);
		@(posedge hclk);
		i_usr.op(1'b0, 1'b1, 'h6, '0, 4'h0, 1'b0, '0);
		#1 chk("q_a", 36'h3_0f0f_0f0f, q_a);
		@(posedge hclk);
		$display("test registered output done");
		ahb(1'b1, 8'h00, 32'h08);
		i_usr.op(1'b1, 1'b0, 'h6, 36'h9_1111_2222, 4'hf, 1'b1, 'h6);
		#1 chk("q_b", 36'h3_0f0f_0f0f, q_b);
		@(posedge hclk);
		ahb(1'b0, 8'h08, 32'h0);
		chk("status", W'(32'h11), W'(r));
		ahb(1'b1, 8'h00, 32'h00);
		i_usr.op(1'b1, 1'b0, 'h6, 36'h6_7777_8888, 4'hf, 1'b1, 'h6);
		#1 chk("q_b", '0, q_b);
		@(posedge hclk);
		$display("test read during write done");
		i_usr.op(1'b1, 1'b0, 'h0, '0, 4'hf, 1'b0, '0);
		@(posedge hclk);
		ahb(1'b1, 8'h04, 32'hf0);
		i_usr.op(1'b1, 1'b0, 'h3, W'(1), 4'hf, 1'b0, '0);
		@(posedge hclk);
		i_usr.op(1'b0, 1'b0, '0, '0, 4'h0, 1'b1, 'h0);
		#1 chk("q_b", 36'h0_0000_0008, q_b);
		@(posedge hclk);
		inclr_a <= 1'b1;
		inclr_b <= 1'b1;
		#1 chk("q_b", 36'h0_0000_0008, q_b);
		@(posedge hclk);
		inclr_a <= 1'b0;
		inclr_b <= 1'b0;
		#1 chk("q_b", '0, q_b);
		@(posedge hclk);
		$display("test mixed width and clear done");
		ahb(1'b1, 8'h04, 32'hff);
		i_usr.op(1'b1, 1'b0, 'h9, 36'ha_5a5a_a5a5, 4'hf, 1'b0, '0);
		@(posedge hclk);
		ahb(1'b1, 8'h00, 32'h04);
		// Read-only use: contents loaded once, write enables now held low
		i_usr.op(1'b0, 1'b1, 'h9, '0, 4'h0, 1'b1, 'h9);
		#1 chk("q_a", 36'ha_5a5a_a5a5, q_a);
		chk("q_b", 36'ha_5a5a_a5a5, q_b);
		@(posedge hclk);
		ahb(1'b1, 8'h00, 32'h01);
		i_usr.op(1'b0, 1'b1, 'h5, '0, 4'h0, 1'b1, 'h9);
		#1 chk("q_a", 36'h5_1234_56dd, q_a);
		chk("q_b", 36'ha_5a5a_a5a5, q_b);
		@(posedge hclk);
		ahb(1'b1, 8'h00, 32'h03);
		// Port A owns the lower half, so its top address bit is dropped
		i_usr.op(1'b1, 1'b0, 'h49, 36'hc_3c3c_c3c3, 4'hf, 1'b0, '0);
		#1 chk("q_a", 36'hc_3c3c_c3c3, q_a);
		@(posedge hclk);
		// Flow-through bypasses the port B output register set in this control word
		ahb(1'b1, 8'h00, 32'h60);
		i_usr.op(1'b0, 1'b0, '0, '0, 4'h0, 1'b1, 'h9);
		#1 chk("q_b", 36'hc_3c3c_c3c3, q_b);
		@(posedge hclk);
		$display("test modes done");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 8'h00, 32'h0);
		chk("control", W'(32'h38), W'(r));
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule : ceram_top_tb

bind ceram_top ceram_checker #(.ram_class(ram_class)) i_chk (
	.hclk(hclk),
	.hresetn(hresetn),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.hrdata(hrdata),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.clken_a(clken_a),
	.inclr_a(inclr_a),
	.outclr_a(outclr_a),
	.q_a(q_a),
	.clken_b(clken_b),
	.inclr_b(inclr_b),
	.outclr_b(outclr_b),
	.q_b(q_b)
);

//--- verification/ceram_user.sv
`timescale 1ns/10ps
module ceram_user #(
	parameter int ram_class = ceram_pkg::CLS_MEDIUM,
	localparam int AB = ceram_pkg::port_addr_bits(ram_class),
	localparam int W = ceram_pkg::word_bits(ram_class),
	localparam int BE = ceram_pkg::data_bits(ram_class) / 8
) (
	// Fabric clock
	input wire logic hclk,
	// Port A requests
	output logic clken_a,
	output logic [AB-1:0] addr_a,
	output logic [W-1:0] wdata_a,
	output logic wren_a,
	output logic rden_a,
	output logic [BE-1:0] byteen_a,
	// Port B requests, reads only
	output logic clken_b,
	output logic [AB-1:0] addr_b,
	output logic [W-1:0] wdata_b,
	output logic wren_b,
	output logic rden_b,
	output logic [BE-1:0] byteen_b
);
	initial begin
		clken_a = 1'b0;
		addr_a = '0;
		wdata_a = '0;
		wren_a = 1'b0;
		rden_a = 1'b0;
		byteen_a = '0;
		clken_b = 1'b0;
		addr_b = '0;
		wdata_b = '0;
		wren_b = 1'b0;
		rden_b = 1'b0;
		byteen_b = '1;
	end

	// Called just after an edge; released addresses and write data are inverted so stale data never looks valid
	task automatic op(input logic aw, input logic ar, input logic [AB-1:0] aa, input logic [W-1:0] ad,
		input logic [BE-1:0] be, input logic br, input logic [AB-1:0] ba);
		clken_a <= aw || ar;
		wren_a <= aw;
		rden_a <= ar && !aw;
		addr_a <= aa;
		wdata_a <= ad;
		byteen_a <= be;
		clken_b <= br;
		rden_b <= br;
		addr_b <= ba;
		@(posedge hclk);
		clken_a <= 1'b0;
		wren_a <= 1'b0;
		rden_a <= 1'b0;
		clken_b <= 1'b0;
		rden_b <= 1'b0;
		addr_a <= ~aa;
		wdata_a <= ~ad;
		addr_b <= ~ba;
	endtask : op
endmodule : ceram_user
